// file: prot_pkg.sv
package prot_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_RESTART_CFG = 8'h00;
  localparam logic [7:0] OFF_RESTART_TIME = 8'h04;
  localparam logic [7:0] OFF_TORQUE_CFG = 8'h08;
  localparam logic [7:0] OFF_HEAT_CFG = 8'h0C;
  localparam logic [7:0] OFF_OUTSEL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // field positions
  localparam int POS_LIMIT = 0;
  localparam int POS_RELAY = 4;
  localparam int POS_RIDE = 5;
  localparam int POS_INTERVAL = 0;
  localparam int POS_BASEBLOCK = 16;
  localparam int POS_TSEL = 0;
  localparam int POS_TLEVEL = 4;
  localparam int POS_TTIME = 16;
  localparam int POS_HLEVEL = 0;
  localparam int POS_HACT = 8;
  localparam int POS_HRED = 16;
  localparam int POS_OSEL_TWO = 8;
  // reset values and legal range limits
  localparam logic [3:0] RST_LIMIT = 4'h0;
  localparam logic [3:0] MAX_LIMIT = 4'hA;
  localparam logic RST_RELAY = 1'b0;
  localparam logic [1:0] RST_RIDE = 2'h0;
  localparam logic [12:0] RST_INTERVAL = 13'h0708;
  localparam logic [12:0] MIN_INTERVAL = 13'h0005;
  localparam logic [12:0] MAX_INTERVAL = 13'h1770;
  localparam logic [12:0] RST_BASEBLOCK = 13'h0005;
  localparam logic [3:0] RST_TSEL = 4'h0;
  localparam logic [9:0] RST_TLEVEL = 10'h00F;
  localparam logic [9:0] MAX_TLEVEL = 10'h12C;
  localparam logic [7:0] RST_TTIME = 8'h64;
  localparam logic [7:0] MAX_TTIME = 8'h64;
  localparam logic [7:0] RST_HLEVEL = 8'h5F;
  localparam logic [7:0] MIN_HLEVEL = 8'h32;
  localparam logic [7:0] MAX_HLEVEL = 8'h82;
  localparam logic [2:0] RST_HACT = 3'h4;
  localparam logic [9:0] RST_HRED = 10'h0C8;
  localparam logic [7:0] RST_OSEL = 8'h00;
  // output function codes and hysteresis
  localparam logic [7:0] OF_TRQ_NO = 8'h0B;
  localparam logic [7:0] OF_TRQ_NC = 8'h17;
  localparam logic [7:0] OF_RESTART_EN = 8'h1E;
  localparam logic [7:0] OF_HEAT_PRE = 8'h20;
  localparam logic [10:0] TRQ_HYST = 11'h00A;
  // fault flag bit positions
  localparam int NUM_FAULTS = 11;
  localparam int FLT_TORQUE = 5;
  localparam int FLT_BUS_LOW = 9;
  localparam int NUM_THERM = 3;
  // timing: all timers count a 0.1 s tick
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint TICK_MS = 100;
  localparam int TICK_CYCLES = int'((TICK_MS * 64'd1000000000) / CLK_PERIOD_PS);
  localparam int QUIET_MIN = 10;
  localparam logic [12:0] QUIET_TICKS = 13'(QUIET_MIN * 600);
  // heat action codes
  localparam logic [2:0] HA_RAMP = 3'h0;
  localparam logic [2:0] HA_COAST = 3'h1;
  localparam logic [2:0] HA_FAST = 3'h2;
  localparam logic [2:0] HA_REDUCE = 3'h4;
  typedef enum logic [2:0] {
    ST_RUN, ST_BASEBLOCK, ST_CHECK, ST_ATTEMPT, ST_WAIT, ST_LOCKED
  } rs_state_t;
endpackage : prot_pkg

// file: drive_protection_supervisor.sv
`timescale 1ns/100ps
// How it works
// - restart attempt limit 0..10, default zero
// - baseblock after fault, then recheck fault
// - clean restart forces speed search, counts one
// - failed restart counts if motor was rotated
// - persisting fault: no attempt, count unchanged
// - wait restart interval 0.5..600 s, default 180
// - count clears: quiet ten minutes, power, reset
// - relay select: fault relay during restart
// - only listed faults may auto restart
// - undervoltage restart needs ride-through 1 or 2
// - output code 1E shows restart possible
// - torque select decodes type, action, check window
// - torque level 0..300 percent, default 15
// - torque detect after level held detect time
// - codes B and 17 show torque N.O./N.C.
// - overtorque clears 10 percent below level
// - undertorque clears 10 percent above level
// - heat prealarm level 50..130 C, default 95
// - heat prealarm action selection 0..4
// - alarm-and-reduce keeps running, lowers speed
// - output code 20 follows heatsink over level
// - reduction in percent of max, default 20
module drive_protection_supervisor
  import prot_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // drive status pins
  input wire logic [NUM_FAULTS-1:0] FAULT_FLAGS,
  input wire logic FAULT_OTHER,
  input wire logic RESET_KEY,
  input wire logic RUN_ACTIVE,
  input wire logic SPEED_AGREE,
  input wire logic RESTART_OK,
  input wire logic RESTART_FAIL,
  input wire logic ROTATE_TRIED,
  input wire logic [9:0] OUT_CURRENT,
  input wire logic [8*NUM_THERM-1:0] HS_TEMP,
  // run and speed commands
  output logic BASEBLOCK,
  output logic RESTART_CMD,
  output logic SEARCH_FORCE,
  output logic STOP_RAMP,
  output logic STOP_COAST,
  output logic STOP_FAST,
  output logic [9:0] SPEED_REDUCE,
  // indications
  output logic FAULT_RELAY,
  output logic TORQUE_ALARM,
  output logic TORQUE_FAULT,
  output logic HEAT_ALARM,
  output logic [1:0] DOUT
);
  localparam int SW = NUM_FAULTS + 8 + 10 + 8 * NUM_THERM;

  // two-flop synchroniser for every pin input
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {FAULT_FLAGS, FAULT_OTHER, RESET_KEY, RUN_ACTIVE, SPEED_AGREE, RESTART_OK,
                  RESTART_FAIL, ROTATE_TRIED, 1'b0, OUT_CURRENT, HS_TEMP};
      sync2_r <= sync1_r;
    end
  end
  wire [NUM_FAULTS-1:0] flt_s = sync2_r[SW-1 -: NUM_FAULTS];
  wire other_s = sync2_r[SW-NUM_FAULTS-1];
  wire key_s = sync2_r[SW-NUM_FAULTS-2];
  wire run_s = sync2_r[SW-NUM_FAULTS-3];
  wire agree_s = sync2_r[SW-NUM_FAULTS-4];
  wire ok_s = sync2_r[SW-NUM_FAULTS-5];
  wire fail_s = sync2_r[SW-NUM_FAULTS-6];
  wire rot_s = sync2_r[SW-NUM_FAULTS-7];
  wire [9:0] cur_s = sync2_r[8*NUM_THERM+9 -: 10];
  wire [8*NUM_THERM-1:0] temp_s = sync2_r[8*NUM_THERM-1:0];

  // apb decode; one wait-free access phase, pready registered
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  wire setup_w = PSEL & ~PENABLE;
  wire wr_w = PSEL & PENABLE & PWRITE & pready_r;
  wire hit_cfg = PADDR == OFF_RESTART_CFG;
  wire hit_time = PADDR == OFF_RESTART_TIME;
  wire hit_trq = PADDR == OFF_TORQUE_CFG;
  wire hit_heat = PADDR == OFF_HEAT_CFG;
  wire hit_osel = PADDR == OFF_OUTSEL;
  wire hit_stat = PADDR == OFF_STATUS;
  wire mapped_w = hit_cfg | hit_time | hit_trq | hit_heat | hit_osel | hit_stat;

  // configuration registers
  logic [3:0] limit_r;
  logic relay_sel_r;
  logic [1:0] ride_r;
  logic [12:0] interval_r, bb_time_r;
  logic [3:0] tsel_r;
  logic [9:0] tlevel_r;
  logic [7:0] ttime_r, hlevel_r;
  logic [2:0] hact_r;
  logic [9:0] hred_r;
  logic [7:0] osel_one_r, osel_two_r;

  // limit, interval, torque level and time, and heat level writes clamped to their legal ranges; other fields stored as written
  wire [3:0] wr_limit = PWDATA[POS_LIMIT +: 4];
  wire [3:0] limit_nxt = (wr_limit > MAX_LIMIT) ? MAX_LIMIT : wr_limit;
  wire [12:0] wr_int = PWDATA[POS_INTERVAL +: 13];
  wire [12:0] interval_nxt = (wr_int < MIN_INTERVAL) ? MIN_INTERVAL :
                             (wr_int > MAX_INTERVAL) ? MAX_INTERVAL : wr_int;
  wire [9:0] wr_tlev = PWDATA[POS_TLEVEL +: 10];
  wire [9:0] tlevel_nxt = (wr_tlev > MAX_TLEVEL) ? MAX_TLEVEL : wr_tlev;
  wire [7:0] wr_ttim = PWDATA[POS_TTIME +: 8];
  wire [7:0] ttime_nxt = (wr_ttim > MAX_TTIME) ? MAX_TTIME : wr_ttim;
  wire [7:0] wr_hlev = PWDATA[POS_HLEVEL +: 8];
  wire [7:0] hlevel_nxt = (wr_hlev < MIN_HLEVEL) ? MIN_HLEVEL :
                          (wr_hlev > MAX_HLEVEL) ? MAX_HLEVEL : wr_hlev;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      limit_r <= RST_LIMIT;
      relay_sel_r <= RST_RELAY;
      ride_r <= RST_RIDE;
      interval_r <= RST_INTERVAL;
      bb_time_r <= RST_BASEBLOCK;
      tsel_r <= RST_TSEL;
      tlevel_r <= RST_TLEVEL;
      ttime_r <= RST_TTIME;
      hlevel_r <= RST_HLEVEL;
      hact_r <= RST_HACT;
      hred_r <= RST_HRED;
      osel_one_r <= RST_OSEL;
      osel_two_r <= RST_OSEL;
    end else begin
      if (wr_w && hit_cfg) begin
        limit_r <= limit_nxt;
        relay_sel_r <= PWDATA[POS_RELAY];
        ride_r <= PWDATA[POS_RIDE +: 2];
      end
      if (wr_w && hit_time) begin
        interval_r <= interval_nxt;
        bb_time_r <= PWDATA[POS_BASEBLOCK +: 13];
      end
      if (wr_w && hit_trq) begin
        tsel_r <= PWDATA[POS_TSEL +: 4];
        tlevel_r <= tlevel_nxt;
        ttime_r <= ttime_nxt;
      end
      if (wr_w && hit_heat) begin
        hlevel_r <= hlevel_nxt;
        hact_r <= PWDATA[POS_HACT +: 3];
        hred_r <= PWDATA[POS_HRED +: 10];
      end
      if (wr_w && hit_osel) begin
        osel_one_r <= PWDATA[7:0];
        osel_two_r <= PWDATA[POS_OSEL_TWO +: 8];
      end
    end
  end

  // 0.1 s tick; the divider is a parameter so simulation can shorten it
  logic [31:0] div_r;
  logic tick_r;
  wire div_end = div_r == 32'(TICK_DIV - 1);
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_end ? '0 : div_r + 32'h1;
      tick_r <= div_end;
    end
  end

  // torque detection decode
  wire t_en = (tsel_r != 4'h0) && (tsel_r <= 4'h8);
  wire t_over = tsel_r <= 4'h4;
  wire t_flt = (tsel_r == 4'h3) || (tsel_r == 4'h4) || (tsel_r == 4'h7) || (tsel_r == 4'h8);
  wire t_window = run_s & (~tsel_r[0] | agree_s);
  wire [10:0] cur_w = {1'b0, cur_s};
  wire [10:0] lev_w = {1'b0, tlevel_r};
  wire t_beyond = t_over ? (cur_w > lev_w) : (cur_w < lev_w);
  wire t_back = t_over ? (cur_w + TRQ_HYST < lev_w) : (cur_w > lev_w + TRQ_HYST);
  logic [7:0] t_cnt_r;
  logic t_det_r;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      t_cnt_r <= '0;
      t_det_r <= 1'b0;
    end else begin
      if (!(t_en && t_window && t_beyond))
        t_cnt_r <= '0;
      else if (tick_r && t_cnt_r < ttime_r)
        t_cnt_r <= t_cnt_r + 8'h01;
      if (!t_en || t_back)
        t_det_r <= 1'b0;
      else if (t_window && t_beyond && t_cnt_r >= ttime_r)
        t_det_r <= 1'b1;
    end
  end
  wire trq_trip_w = t_det_r & t_flt & t_over; // overtorque fault is a restartable trip
  wire trq_stop_w = t_det_r & t_flt & ~t_over; // undertorque fault never restarts

  // heatsink thermistor compare, any one over level raises the prealarm
  wire [NUM_THERM-1:0] hot_each;
  genvar g;
  generate
    for (g = 0; g < NUM_THERM; g++) begin : g_therm
      assign hot_each[g] = temp_s[8*g +: 8] > hlevel_r;
    end
  endgenerate
  wire hot_w = |hot_each;

  // restart sequencer
  rs_state_t state_r, state_nxt;
  logic [3:0] count_r;
  logic [12:0] timer_r;
  logic key_d_r;
  wire key_press = key_s & ~key_d_r;
  wire uv_ok = (ride_r == 2'h1) || (ride_r == 2'h2);
  wire [NUM_FAULTS-1:0] flt_all = flt_s | (NUM_FAULTS'(trq_trip_w) << FLT_TORQUE);
  wire fault_now = (|flt_all) | other_s | trq_stop_w;
  wire restartable = ~other_s & ~trq_stop_w & (~flt_all[FLT_BUS_LOW] | uv_ok);
  wire below_limit = count_r < limit_r;
  wire counts_w = ok_s | (fail_s & rot_s);
  wire tmr_done_bb = tick_r && (timer_r >= bb_time_r);
  wire tmr_done_wait = tick_r && (timer_r >= interval_r);
  wire quiet_done = tick_r && (timer_r >= QUIET_TICKS);

  // next state; counter is updated in the clocked state process below
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (fault_now)
          state_nxt = (restartable && below_limit) ? ST_BASEBLOCK : ST_LOCKED;
      end
      ST_BASEBLOCK: if (tmr_done_bb) state_nxt = ST_CHECK;
      ST_CHECK: state_nxt = fault_now ? ST_WAIT : ST_ATTEMPT;
      ST_ATTEMPT: begin
        if (ok_s)
          state_nxt = ST_RUN;
        else if (fail_s)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (!below_limit)
          state_nxt = ST_LOCKED;
        else if (tmr_done_wait)
          state_nxt = ST_CHECK;
      end
      ST_LOCKED: if (key_press) state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  wire count_inc = (state_r == ST_ATTEMPT) && counts_w && below_limit;
  wire quiet_clr = (state_r == ST_RUN) && !fault_now && quiet_done;
  wire key_clr = (state_r == ST_LOCKED) && key_press;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_RUN;
      count_r <= '0;
      timer_r <= '0;
      key_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      key_d_r <= key_s;
      // the quiet timer restarts at every state change and saturates
      if (state_nxt != state_r)
        timer_r <= '0;
      else if (tick_r && timer_r != 13'h1FFF)
        timer_r <= timer_r + 13'h0001;
      if (key_clr || quiet_clr)
        count_r <= '0;
      else if (count_inc)
        count_r <= count_r + 4'h1;
    end
  end

  // registered outputs
  wire in_restart = (state_r == ST_BASEBLOCK) || (state_r == ST_CHECK) ||
                    (state_r == ST_ATTEMPT) || (state_r == ST_WAIT);
  wire restart_en_w = (state_r != ST_LOCKED) && below_limit;
  wire reduce_w = hot_w && (hact_r == HA_REDUCE);
  function automatic logic dout_sel(input logic [7:0] code, input logic tdet, input logic hot,
                                    input logic ren);
    case (code)
      OF_TRQ_NO: dout_sel = tdet;
      OF_TRQ_NC: dout_sel = ~tdet;
      OF_RESTART_EN: dout_sel = ren;
      OF_HEAT_PRE: dout_sel = hot;
      default: dout_sel = 1'b0;
    endcase
  endfunction : dout_sel

  wire [31:0] status_w = {21'h0, 3'(state_r), restart_en_w, hot_w, t_det_r,
                          state_r == ST_LOCKED, count_r};
  wire [31:0] rd_w = hit_cfg ? {25'h0, ride_r, relay_sel_r, limit_r} :
                     hit_time ? {3'h0, bb_time_r, 3'h0, interval_r} :
                     hit_trq ? {8'h0, ttime_r, 2'h0, tlevel_r, tsel_r} :
                     hit_heat ? {6'h0, hred_r, 5'h0, hact_r, hlevel_r} :
                     hit_osel ? {16'h0, osel_two_r, osel_one_r} :
                     hit_stat ? status_w : 32'h0;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      BASEBLOCK <= 1'b0;
      RESTART_CMD <= 1'b0;
      SEARCH_FORCE <= 1'b0;
      FAULT_RELAY <= 1'b0;
      STOP_RAMP <= 1'b0;
      STOP_COAST <= 1'b0;
      STOP_FAST <= 1'b0;
      SPEED_REDUCE <= '0;
      TORQUE_ALARM <= 1'b0;
      TORQUE_FAULT <= 1'b0;
      HEAT_ALARM <= 1'b0;
      DOUT <= '0;
    end else begin
      pready_r <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      prdata_r <= (setup_w && !PWRITE) ? rd_w : 32'h0;
      BASEBLOCK <= state_r == ST_BASEBLOCK;
      RESTART_CMD <= state_r == ST_ATTEMPT;
      SEARCH_FORCE <= state_r == ST_ATTEMPT;
      FAULT_RELAY <= (state_r == ST_LOCKED) || (in_restart && relay_sel_r);
      STOP_RAMP <= hot_w && (hact_r == HA_RAMP);
      STOP_COAST <= hot_w && (hact_r == HA_COAST);
      STOP_FAST <= hot_w && (hact_r == HA_FAST);
      SPEED_REDUCE <= reduce_w ? hred_r : 10'h000;
      TORQUE_ALARM <= t_det_r & ~t_flt;
      TORQUE_FAULT <= t_det_r & t_flt;
      HEAT_ALARM <= hot_w;
      DOUT <= {dout_sel(osel_two_r, t_det_r, hot_w, restart_en_w),
               dout_sel(osel_one_r, t_det_r, hot_w, restart_en_w)};
    end
  end
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA = prdata_r;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_count_bounded: assert property (count_r <= MAX_LIMIT)
    else $error("attempt count above ten");
  a_baseblock_out: assert property (state_r == ST_BASEBLOCK |=> BASEBLOCK)
    else $error("baseblock not driven");
  a_search_forced: assert property (state_r == ST_ATTEMPT |=> SEARCH_FORCE && RESTART_CMD)
    else $error("restart without forced search");
  a_persist_hold: assert property (state_r == ST_CHECK && fault_now |=> $stable(count_r))
    else $error("count moved on persisting fault");
  a_fail_count: assert property (state_r == ST_ATTEMPT && !ok_s && fail_s && rot_s
    && below_limit |=> count_r == $past(count_r) + 4'h1)
    else $error("rotated failure not counted");
  a_relay_open: assert property (in_restart && !relay_sel_r |=> !FAULT_RELAY)
    else $error("relay closed during restart");
  a_locked_relay: assert property (state_r == ST_LOCKED ##1 state_r == ST_LOCKED
    |-> FAULT_RELAY)
    else $error("lock without relay");
  a_over_clear: assert property (t_det_r && t_en && t_over && cur_w + TRQ_HYST < lev_w
    |=> !t_det_r)
    else $error("overtorque not cleared");
  a_under_clear: assert property (t_det_r && t_en && !t_over && cur_w > lev_w + TRQ_HYST
    |=> !t_det_r)
    else $error("undertorque not cleared");
  a_reduce_out: assert property (reduce_w |=> SPEED_REDUCE == $past(hred_r))
    else $error("reduction not applied");
  a_heat_dout: assert property (osel_one_r == OF_HEAT_PRE && hot_w |=> DOUT[0])
    else $error("prealarm output open");
  c_restart_ok: cover property (state_r == ST_ATTEMPT && ok_s);
  c_locked: cover property (state_r == ST_WAIT ##1 state_r == ST_LOCKED);
  c_torque_det: cover property (!t_det_r ##1 t_det_r);
  c_heat_reduce: cover property (reduce_w);
endmodule : drive_protection_supervisor

// file: motor_model.sv
`timescale 1ns/100ps
// far side of the supervisor: motor and run logic answering restart commands
module motor_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command and scenario controls
  input wire logic restart_cmd,
  input wire logic fail_mode,
  input wire logic slow,
  // result pins
  output logic restart_ok,
  output logic restart_fail,
  output logic rotate_tried
);
  int wait_r;
  // answer after a short or long turn-around, held until the command drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 0;
      restart_ok <= 1'b0;
      restart_fail <= 1'b0;
      rotate_tried <= 1'b0;
    end else if (restart_cmd) begin
      wait_r <= wait_r + 1;
      if (wait_r == (slow ? 9 : 1)) begin
        restart_ok <= !fail_mode;
        restart_fail <= fail_mode;
        rotate_tried <= fail_mode; // a failed try still turned the shaft
      end
    end else begin
      wait_r <= 0;
      restart_ok <= 1'b0;
      restart_fail <= 1'b0;
      rotate_tried <= 1'b0;
    end
  end
endmodule : motor_model

// file: drive_protection_supervisor_tb.sv
`timescale 1ns/100ps
module drive_protection_supervisor_tb;
  import prot_pkg::*;
  localparam int TK = 4;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, restart_ok, restart_fail, rotate_tried;
  logic [10:0] fault_flags = 11'h000;
  logic fault_other = 1'b0;
  logic reset_key = 1'b0;
  logic run_active = 1'b0;
  logic speed_agree = 1'b0;
  logic fail_mode = 1'b0;
  logic slow = 1'b0;
  logic seen_search = 1'b0;
  logic [9:0] out_current = 10'h000;
  logic [23:0] hs_temp = 24'h000000;
  logic baseblock, restart_cmd, search_force, stop_ramp, stop_coast, stop_fast;
  logic fault_relay, torque_alarm, torque_fault, heat_alarm;
  logic [9:0] speed_reduce;
  logic [1:0] dout;
  logic [31:0] rd;
  logic [31:0] seed = 32'hDEAD;
  logic err;
  int failures = 0;
  int samples_checked = 0;
  int model_count = 0;

  // free-running control clock
  always #2 core_clk = ~core_clk;

  drive_protection_supervisor #(.TICK_DIV(TK)) i_dut (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FAULT_FLAGS(fault_flags),
    .FAULT_OTHER(fault_other), .RESET_KEY(reset_key), .RUN_ACTIVE(run_active),
    .SPEED_AGREE(speed_agree), .RESTART_OK(restart_ok), .RESTART_FAIL(restart_fail),
    .ROTATE_TRIED(rotate_tried), .OUT_CURRENT(out_current), .HS_TEMP(hs_temp),
    .BASEBLOCK(baseblock), .RESTART_CMD(restart_cmd), .SEARCH_FORCE(search_force),
    .STOP_RAMP(stop_ramp), .STOP_COAST(stop_coast), .STOP_FAST(stop_fast),
    .SPEED_REDUCE(speed_reduce), .FAULT_RELAY(fault_relay),
    .TORQUE_ALARM(torque_alarm), .TORQUE_FAULT(torque_fault),
    .HEAT_ALARM(heat_alarm), .DOUT(dout)
  );

  motor_model i_motor (
    .clk(core_clk), .rst_n(reset_n), .restart_cmd(restart_cmd),
    .fail_mode(fail_mode), .slow(slow), .restart_ok(restart_ok),
    .restart_fail(restart_fail), .rotate_tried(rotate_tried)
  );

  // remember that a restart came with a forced search
  always @(posedge core_clk) begin
    if (search_force === 1'b1 && restart_cmd === 1'b1) seen_search <= 1'b1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 1, 0);
      close_out();
    end
  endtask : apb

  // poll the sequencer state field with a bounded count
  task automatic wait_state(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[10:8] !== s && n < lim);
    chk("state", 32'(s), 32'(rd[10:8]));
    if (rd[10:8] !== s) close_out();
  endtask : wait_state

  // watched output by number: 0 baseblock, 1 torque alarm, 2 torque fault
  task automatic wait_on(input int w, input logic v, input int lim, input string nm);
    int n;
    logic sg;
    n = 0;
    sg = (w == 0) ? baseblock : (w == 1) ? torque_alarm : torque_fault;
    while (sg !== v && n < lim) begin
      @(posedge core_clk);
      n++;
      sg = (w == 0) ? baseblock : (w == 1) ? torque_alarm : torque_fault;
    end
    chk(nm, 32'(v), 32'(sg));
    if (sg !== v) close_out();
  endtask : wait_on

  task automatic key_press();
    reset_key <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset_key <= 1'b0;
    wait_state(3'h0, 20);
    model_count = 0;
  endtask : key_press

  // hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    chk("run length", 0, 1);
    close_out();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    // register defaults, clamps and an unmapped place
    apb(1'b0, OFF_RESTART_CFG, 32'h0); chk("restart cfg", 32'h0, rd);
    apb(1'b0, OFF_RESTART_TIME, 32'h0); chk("restart time", 32'h00050708, rd);
    apb(1'b0, OFF_TORQUE_CFG, 32'h0); chk("torque cfg", 32'h006400F0, rd);
    apb(1'b0, OFF_HEAT_CFG, 32'h0); chk("heat cfg", 32'h00C8045F, rd);
    apb(1'b0, 8'h18, 32'h0); chk("unmapped error", 1, err);
    apb(1'b1, OFF_RESTART_CFG, 32'h0000000F);
    apb(1'b0, OFF_RESTART_CFG, 32'h0); chk("limit clamp", 32'h0000000A, rd);
    apb(1'b1, OFF_RESTART_TIME, 32'h00010001);
    apb(1'b0, OFF_RESTART_TIME, 32'h0); chk("interval clamp", 32'h00010005, rd);
    apb(1'b1, OFF_TORQUE_CFG, 32'h00FF3FF0);
    apb(1'b0, OFF_TORQUE_CFG, 32'h0); chk("torque clamp", 32'h006412C0, rd);
    apb(1'b1, OFF_HEAT_CFG, 32'h00C80410);
    apb(1'b0, OFF_HEAT_CFG, 32'h0); chk("heat clamp", 32'h00C80432, rd);
    $display("register test done");
    // restart sequence: held fault, clean restart, failed restart, lock
    apb(1'b1, OFF_OUTSEL, 32'h0000171E);
    apb(1'b1, OFF_RESTART_CFG, 32'h00000012);
    repeat (4) @(posedge core_clk);
    chk("restart enabled", 1, dout[0]);
    seed = xs(seed);
    fault_flags <= 11'h001 << (seed % 9);
    wait_on(0, 1'b1, 40, "baseblock");
    chk("relay in restart", 1, fault_relay);
    wait_state(3'h4, 40);
    chk("count held fault", 32'(model_count), 32'(rd[3:0]));
    fault_flags <= 11'h000;
    wait_state(3'h0, 100);
    model_count++;
    chk("count success", 32'(model_count), 32'(rd[3:0]));
    chk("search forced", 1, seen_search);
    fail_mode <= 1'b1;
    slow <= 1'b1;
    fault_flags <= 11'h080;
    wait_on(0, 1'b1, 40, "baseblock");
    fault_flags <= 11'h000;
    wait_state(3'h5, 100);
    model_count++;
    chk("count failed", 32'(model_count), 32'(rd[3:0]));
    chk("locked relay", 1, fault_relay);
    chk("restart disabled", 0, dout[0]);
    fail_mode <= 1'b0;
    slow <= 1'b0;
    key_press();
    chk("count key", 32'(model_count), 32'(rd[3:0]));
    // undervoltage needs ride-through, relay left open
    apb(1'b1, OFF_RESTART_CFG, 32'h00000002);
    fault_flags <= 11'h200;
    wait_state(3'h5, 40);
    fault_flags <= 11'h000;
    key_press();
    apb(1'b1, OFF_RESTART_CFG, 32'h00000022);
    fault_flags <= 11'h200;
    wait_on(0, 1'b1, 40, "baseblock ride");
    chk("relay open", 0, fault_relay);
    fault_flags <= 11'h000;
    wait_state(3'h0, 100);
    model_count++;
    chk("count ride", 32'(model_count), 32'(rd[3:0]));
    repeat (6010 * TK) @(posedge core_clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    model_count = 0;
    chk("count quiet", 32'(model_count), 32'(rd[3:0]));
    fault_other <= 1'b1;
    wait_state(3'h5, 20);
    fault_other <= 1'b0;
    key_press();
    $display("restart test done");
    // torque: over, under, then fault at speed agreement
    apb(1'b1, OFF_OUTSEL, 32'h0000170B);
    run_active <= 1'b1;
    out_current <= 10'h03C;
    apb(1'b1, OFF_TORQUE_CFG, 32'h00020322);
    repeat (4) @(posedge core_clk);
    chk("torque early", 0, torque_alarm);
    wait_on(1, 1'b1, 40, "overtorque");
    chk("torque outputs", 32'h1, 32'(dout));
    chk("alarm only", 0, torque_fault);
    out_current <= 10'h02D;
    repeat (12) @(posedge core_clk);
    chk("over hyst", 1, torque_alarm);
    out_current <= 10'h027;
    wait_on(1, 1'b0, 20, "over clear");
    apb(1'b1, OFF_TORQUE_CFG, 32'h00020326);
    out_current <= 10'h01E;
    wait_on(1, 1'b1, 40, "undertorque");
    out_current <= 10'h037;
    repeat (12) @(posedge core_clk);
    chk("under hyst", 1, torque_alarm);
    out_current <= 10'h03D;
    wait_on(1, 1'b0, 20, "under clear");
    apb(1'b1, OFF_RESTART_CFG, 32'h0);
    apb(1'b1, OFF_TORQUE_CFG, 32'h00020323);
    out_current <= 10'h03C;
    repeat (40) @(posedge core_clk);
    chk("no agree", 0, torque_fault);
    speed_agree <= 1'b1;
    wait_on(2, 1'b1, 40, "torque fault");
    wait_state(3'h5, 20);
    out_current <= 10'h000;
    key_press();
    $display("torque test done");
    // heat pre-alarm: every action, then just at the level
    // both outputs on the prealarm code so each select path is exercised
    apb(1'b1, OFF_OUTSEL, 32'h00002020);
    for (int a = 0; a < 5; a++) begin
      apb(1'b1, OFF_HEAT_CFG, 32'h0096005F | (32'(a) << 8));
      seed = xs(seed);
      hs_temp <= {8'h60, 2'b00, seed[13:8], 2'b00, seed[5:0]};
      repeat (8) @(posedge core_clk);
      chk("heat alarm", 1, heat_alarm);
      chk("stops", (a < 3) ? (32'h1 << a) : 32'h0, {stop_fast, stop_coast, stop_ramp});
      chk("reduce", (a == 4) ? 32'h96 : 32'h0, 32'(speed_reduce));
      chk("prealarm out", 32'h3, 32'(dout));
      hs_temp <= {8'h5F, 16'h0000};
      repeat (8) @(posedge core_clk);
      chk("heat at level", 0, heat_alarm);
      chk("prealarm off", 0, 32'(dout));
    end
    $display("heat test done");
    close_out();
  end
endmodule : drive_protection_supervisor_tb
